/* core/socket_status_pkg.sv */
package socket_status_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] EVENT_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] FORCE_OFFSET = 8'h0C;
    localparam logic [7:0] CONTROL_OFFSET = 8'h40;

    // ------------------------------------------------------------
    // status, force and control word bit positions
    // ------------------------------------------------------------
    localparam int BIT_SUPPLIES_YY = 31;
    localparam int BIT_SUPPLIES_XX = 30;
    localparam int BIT_SUPPLIES_THREE = 29;
    localparam int BIT_SUPPLIES_FIVE = 28;
    localparam int BIT_ACCEPT_LO = 10;
    localparam int BIT_INVALID_SUPPLY = 9;
    localparam int BIT_REMOVAL_LOSS = 8;
    localparam int BIT_UNKNOWN_CARD = 7;
    localparam int BIT_READY_IRQ = 6;
    localparam int BIT_CARDBUS = 5;
    localparam int BIT_SIXTEEN = 4;
    localparam int BIT_POWER = 3;
    localparam int BIT_DETECT_TWO = 2;
    localparam int BIT_DETECT_ONE = 1;
    localparam int BIT_STATUS_CHANGE = 0;
    localparam int BIT_FORCE_RETEST = 14;
    localparam int BIT_CTRL_NO_THREE = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] ACCEPT_RESET = 4'h0;
    localparam logic [3:0] EVENT_RESET = 4'h0;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic readyIrq;
        logic detectTwo;
        logic detectOne;
        logic statusChange;
    } card_pins_s;

    typedef struct packed {
        logic [3:0] accepts;
        logic cardBus;
        logic sixteenBit;
        logic unknown;
    } card_info_s;

    typedef enum logic [1:0] {
        IDLE,
        IDENTIFY,
        SETTLE
    } ident_e;

endpackage : socket_status_pkg

/* core/sync_event_edge.sv */
`timescale 1ns/100ps
`default_nettype none

// level to change pulse; cardbus mode filters out falling edges
module sync_event_edge (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic level,
    input wire logic risingOnly,
    output logic changed
);
    logic last;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            last <= 1'b0;
        end else if (clkEn) begin
            last <= level;
        end
    end

    assign changed = clkEn && (level != last) && (!risingOnly || level);
endmodule : sync_event_edge

`default_nettype wire

/* core/socket_present_state_status.sv */
// Strobed register access was decided locally.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - status word sits at offset 08h
// - bit 28 five-volt capability reads one
// - bit 29 one unless control bit six
// - bits 31 and 30 read zero
// - bits 27 to 14 read zero
// - card voltage bits, settable by force
// - card info captured at insertion or retest
// - detect changes hidden during identification
// - bit 9 invalid supply request flag
// - bit 8 removal data loss flag
// - bit 7 unknown card, held until valid
// - bit 6 mirrors ready/irq pin
// - bits 5,4 card type held until insertion, retest or force write
// - bit 3 read/write power state
// - bits 2,1 mirror detect pins
// - bit 0 mirrors status-change pin
// - force writes show in status word
// - power/detect changes set event bits
// - cardbus rising edge, 16-bit both edges
// - retest force reinterrogates and refreshes
module socket_present_state_status #(
    parameter int IDENT_CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [31:0] rdData,
    input wire socket_status_pkg::card_pins_s pins,
    input wire socket_status_pkg::card_info_s probeInfo,
    input wire logic probeValid,
    input wire logic badSupplyReq,
    input wire logic removalLoss,
    output logic powerControlEnable,
    output logic identifying
);
    import socket_status_pkg::*;

    initial begin
        if (IDENT_CYCLES < 1 || IDENT_CYCLES > 255) begin
            $error("IDENT_CYCLES out of range");
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : hit

    logic wrStatus, wrForce, wrEvent, wrCtrl;
    assign wrStatus = clkEn && wrStrobe && hit(addr, STATUS_OFFSET);
    assign wrForce = clkEn && wrStrobe && hit(addr, FORCE_OFFSET);
    assign wrEvent = clkEn && wrStrobe && hit(addr, EVENT_OFFSET);
    assign wrCtrl = clkEn && wrStrobe && hit(addr, CONTROL_OFFSET);

    // ------------------------------------------------------------
    // identification sequence
    // ------------------------------------------------------------
    ident_e state;
    logic [7:0] identCount;
    logic insertEdge, cardPresent, lastPresent;
    logic retest;
    assign cardPresent = !pins.detectOne && !pins.detectTwo;
    assign retest = wrForce && wrData[BIT_FORCE_RETEST];
    assign insertEdge = clkEn && cardPresent && !lastPresent;
    assign identifying = state != IDLE;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lastPresent <= 1'b0;
        end else if (clkEn) begin
            lastPresent <= cardPresent;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= IDLE;
            identCount <= 8'h00;
        end else if (clkEn) begin
            unique case (state)
                IDLE: begin
                    if (insertEdge || retest) begin
                        state <= IDENTIFY;
                        identCount <= 8'(IDENT_CYCLES);
                    end
                end
                IDENTIFY: begin
                    if (probeValid) begin
                        state <= SETTLE;
                    end
                end
                SETTLE: begin
                    if (identCount == 8'h01) begin
                        state <= IDLE;
                    end
                    identCount <= identCount - 8'h01;
                end
                default: state <= IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // captured card information
    // ------------------------------------------------------------
    card_info_s info;
    logic captureNow;
    assign captureNow = clkEn && state == IDENTIFY && probeValid;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            info.accepts <= ACCEPT_RESET;
            info.cardBus <= 1'b0;
            info.sixteenBit <= 1'b0;
            info.unknown <= 1'b0;
        end else if (captureNow) begin
            info.accepts <= probeInfo.accepts;
            info.cardBus <= probeInfo.cardBus;
            info.sixteenBit <= probeInfo.sixteenBit;
            info.unknown <= probeInfo.unknown;
        end else if (wrForce) begin
            info.accepts <= info.accepts | wrData[BIT_ACCEPT_LO +: 4];
            info.cardBus <= wrData[BIT_CARDBUS];
            info.sixteenBit <= wrData[BIT_SIXTEEN];
            info.unknown <= wrData[BIT_UNKNOWN_CARD];
        end
    end

    // ------------------------------------------------------------
    // error flags
    // ------------------------------------------------------------
    logic invalidSupply, removalLossFlag;

    // set by hardware, force writes; set wins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            invalidSupply <= 1'b0;
        end else if (clkEn && badSupplyReq) begin
            invalidSupply <= 1'b1;
        end else if (wrForce) begin
            invalidSupply <= wrData[BIT_INVALID_SUPPLY];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            removalLossFlag <= 1'b0;
        end else if (clkEn && removalLoss) begin
            removalLossFlag <= 1'b1;
        end else if (wrForce) begin
            removalLossFlag <= wrData[BIT_REMOVAL_LOSS];
        end
    end

    // ------------------------------------------------------------
    // power state and control
    // ------------------------------------------------------------
    logic powerState, noThreeVolt;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            powerState <= 1'b0;
        end else if (wrStatus) begin
            powerState <= wrData[BIT_POWER];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            noThreeVolt <= 1'b0;
        end else if (wrCtrl) begin
            noThreeVolt <= wrData[BIT_CTRL_NO_THREE];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            powerControlEnable <= 1'b1;
        end else if (retest) begin
            powerControlEnable <= 1'b1;
        end else if (wrForce && |wrData[BIT_ACCEPT_LO +: 4]) begin
            powerControlEnable <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // detect pins, frozen while identifying
    // ------------------------------------------------------------
    logic detectOne, detectTwo;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            detectOne <= 1'b1;
            detectTwo <= 1'b1;
        end else if (clkEn && !identifying && !insertEdge) begin
            detectOne <= pins.detectOne;
            detectTwo <= pins.detectTwo;
        end
    end

    // ------------------------------------------------------------
    // events
    // ------------------------------------------------------------
    logic [3:0] events, changes;
    logic lastPower, statusEdge;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lastPower <= 1'b0;
        end else if (clkEn) begin
            lastPower <= powerState;
        end
    end

    sync_event_edge u_change_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .level(pins.statusChange),
        .risingOnly(info.cardBus),
        .changed(statusEdge)
    );

    always_comb begin
        changes[BIT_STATUS_CHANGE] = statusEdge;
        changes[BIT_POWER] = clkEn && (powerState != lastPower);
        changes[BIT_DETECT_TWO] = clkEn && (detectTwo != pins.detectTwo) && !identifying;
        changes[BIT_DETECT_ONE] = clkEn && (detectOne != pins.detectOne) && !identifying;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            events <= EVENT_RESET;
        end else if (clkEn) begin
            events <= changes
                | (wrForce ? wrData[3:0] : 4'h0)
                | (events & ~(wrEvent ? wrData[3:0] : 4'h0));
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [31:0] statusWord;

    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[BIT_SUPPLIES_FIVE] = 1'b1;
        statusWord[BIT_SUPPLIES_THREE] = !noThreeVolt;
        statusWord[BIT_ACCEPT_LO +: 4] = info.accepts;
        statusWord[BIT_INVALID_SUPPLY] = invalidSupply;
        statusWord[BIT_REMOVAL_LOSS] = removalLossFlag;
        statusWord[BIT_UNKNOWN_CARD] = info.unknown;
        statusWord[BIT_READY_IRQ] = pins.readyIrq;
        statusWord[BIT_CARDBUS] = info.cardBus;
        statusWord[BIT_SIXTEEN] = info.sixteenBit;
        statusWord[BIT_POWER] = powerState;
        statusWord[BIT_DETECT_TWO] = detectTwo;
        statusWord[BIT_DETECT_ONE] = detectOne;
        statusWord[BIT_STATUS_CHANGE] = pins.statusChange;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdData <= UNMAPPED_READ;
        end else if (clkEn && rdStrobe) begin
            unique case (addr)
                STATUS_OFFSET: rdData <= statusWord;
                EVENT_OFFSET: rdData <= {28'h000_0000, events};
                CONTROL_OFFSET: rdData <= {25'h000_0000, noThreeVolt, 6'h00};
                default: rdData <= UNMAPPED_READ;
            endcase
        end else if (clkEn) begin
            rdData <= UNMAPPED_READ;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_five_volt_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && rdStrobe && addr == STATUS_OFFSET |=> rdData[BIT_SUPPLIES_FIVE])
        else $error("five volt bit not one");
    chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && rdStrobe && addr == STATUS_OFFSET |=> rdData[27:14] == 14'h0000 && !rdData[31]
            && !rdData[30])
        else $error("reserved bits nonzero");
    chk_three_volt_ovr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && rdStrobe && addr == STATUS_OFFSET |=> rdData[BIT_SUPPLIES_THREE] == !noThreeVolt)
        else $error("three volt bit wrong");
    chk_info_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !captureNow && !wrForce |=> $stable(info.cardBus) && $stable(info.accepts))
        else $error("card info changed outside capture");
    chk_detect_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
        identifying && $past(identifying) |-> $stable(detectOne) && $stable(detectTwo))
        else $error("detect changed during identification");
    chk_power_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrStatus |=> powerState == $past(wrData[BIT_POWER]))
        else $error("power state not written");
    chk_event_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        changes[BIT_POWER] |=> events[BIT_POWER])
        else $error("power event lost");
    chk_read_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && rdStrobe && !wrStrobe && changes == 4'h0 |=> $stable(events))
        else $error("read changed events");
    sequence seq_ident_held;
        identifying ##1 identifying;
    endsequence
    chk_retest_probe: assert property (@(posedge clk_sys) disable iff (!rst_n)
        retest && state == IDLE |=> seq_ident_held)
        else $error("retest did not start identification");
endmodule : socket_present_state_status

`default_nettype wire

/* sim/card_model.sv */
`timescale 1ns/100ps
`default_nettype none

// card in the socket: pulls both detect pins low while present and answers
// interrogation after a delay
module card_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic present,
    input wire logic identifying,
    input wire socket_status_pkg::card_info_s cardInfo,
    output logic [1:0] detectLevel,
    output socket_status_pkg::card_info_s probeInfo,
    output logic probeValid
);
    import socket_status_pkg::*;
    localparam int ANSWER_DELAY = 6;
    int waitCount;

    // empty slot: detect pins float to their pull-up level
    assign detectLevel = present ? 2'b00 : 2'b11;

    // slow answer, so status can be read mid-identification;
    // outside an answer the info bus toggles so a stale value is never seen
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            waitCount <= 0;
            probeValid <= 1'b0;
            probeInfo <= '0;
        end else if (!identifying || waitCount < ANSWER_DELAY) begin
            waitCount <= identifying ? waitCount + 1 : 0;
            probeValid <= 1'b0;
            probeInfo <= ~probeInfo;
        end else begin
            probeValid <= 1'b1;
            probeInfo <= cardInfo;
        end
    end
endmodule : card_model

`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import socket_status_pkg::*;
    logic clk_sys;
    logic rst_n;
    logic clkEn;
    logic [7:0] addr;
    logic [31:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
    logic [31:0] rdData;
    logic readyLevel;
    logic statusLevel;
    logic [1:0] detectLevel;
    card_pins_s pins;
    card_info_s probeInfo;
    card_info_s cardInfo;
    logic probeValid;
    logic present;
    logic badSupplyReq;
    logic removalLoss;
    logic powerControlEnable;
    logic identifying;
    int err_count = 0;
    int tests_run = 0;

    assign pins = {readyLevel, detectLevel, statusLevel};

    socket_present_state_status #(.IDENT_CYCLES(2)) i_socket_present_state_status (
        .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .pins(pins),
        .probeInfo(probeInfo), .probeValid(probeValid), .badSupplyReq(badSupplyReq),
        .removalLoss(removalLoss), .powerControlEnable(powerControlEnable),
        .identifying(identifying));

    card_model i_card_model (.clk_sys(clk_sys), .rst_n(rst_n), .present(present),
        .identifying(identifying), .cardInfo(cardInfo), .detectLevel(detectLevel),
        .probeInfo(probeInfo), .probeValid(probeValid));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // bus and checking
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk_sys);
        wrStrobe <= 1'b0;
    endtask : reg_write

    // read data stands only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        #1;
        check(rdData & mask, exp);
    endtask : rdchk

    task automatic wait_ident(input logic level);
        int n;
        n = 0;
        while (identifying !== level && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (identifying !== level) begin
            err_count++;
            $display("mismatch at %0t: identification handshake timed out", $time);
            finish_test();
        end
    endtask : wait_ident

    task automatic pins_to(input logic rdy, input logic sts);
        @(posedge clk_sys);
        readyLevel <= rdy;
        statusLevel <= sts;
        repeat (4) @(posedge clk_sys);
    endtask : pins_to

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        rdchk(STATUS_OFFSET, 32'hFFFF_FFFF, 32'h3000_0006);
        rdchk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
        rdchk(CONTROL_OFFSET, 32'h0000_0040, 32'h0000_0000);
        reg_write(CONTROL_OFFSET, 32'h0000_0040);
        rdchk(STATUS_OFFSET, 32'hF000_0000, 32'h1000_0000);
        reg_write(CONTROL_OFFSET, 32'h0000_0000);
        rdchk(STATUS_OFFSET, 32'hF000_0000, 32'h3000_0000);
        $display("reset and capability test done");
    endtask : test_reset

    task automatic test_power;
        reg_write(STATUS_OFFSET, 32'h0000_0008);
        rdchk(STATUS_OFFSET, 32'h0000_0008, 32'h0000_0008);
        rdchk(EVENT_OFFSET, 32'hFFFF_FFFF, 32'h0000_0008);
        reg_write(EVENT_OFFSET, 32'h0000_0008);
        reg_write(STATUS_OFFSET, 32'h0000_0000);
        rdchk(STATUS_OFFSET, 32'h0000_0008, 32'h0000_0000);
        reg_write(EVENT_OFFSET, 32'h0000_000F);
        reg_write(FORCE_OFFSET, 32'h0000_0007);
        rdchk(EVENT_OFFSET, 32'hFFFF_FFFF, 32'h0000_0007);
        reg_write(EVENT_OFFSET, 32'h0000_000F);
        // clock enable low: the power write must be ignored
        clkEn <= 1'b0;
        reg_write(STATUS_OFFSET, 32'h0000_0008);
        clkEn <= 1'b1;
        rdchk(STATUS_OFFSET, 32'h0000_0008, 32'h0000_0000);
        $display("power state test done");
    endtask : test_power

    // cb: captured card is cardbus, so only a rising status edge counts
    task automatic test_pins(input logic cb);
        pins_to(1'b1, 1'b1);
        rdchk(STATUS_OFFSET, 32'h0000_0041, 32'h0000_0041);
        rdchk(EVENT_OFFSET, 32'h0000_0001, 32'h0000_0001);
        reg_write(EVENT_OFFSET, 32'h0000_0001);
        rdchk(STATUS_OFFSET, 32'h0000_0041, 32'h0000_0041);
        rdchk(EVENT_OFFSET, 32'h0000_0001, 32'h0000_0000);
        pins_to(1'b0, 1'b0);
        rdchk(STATUS_OFFSET, 32'h0000_0041, 32'h0000_0000);
        rdchk(EVENT_OFFSET, 32'h0000_0001, {31'h0, !cb});
        reg_write(EVENT_OFFSET, 32'h0000_000F);
        $display("pin mirror test done");
    endtask : test_pins

    task automatic test_insert(input logic [3:0] acc, input logic cb, input logic unk);
        logic [31:0] exp;
        exp = ({28'h0, acc} << 10) | ({31'h0, unk} << 7) | ({31'h0, cb} << 5);
        exp = exp | ({31'h0, !cb && !unk} << 4);
        cardInfo <= '{accepts: acc, cardBus: cb, sixteenBit: !cb && !unk, unknown: unk};
        present <= 1'b1;
        wait_ident(1'b1);
        rdchk(STATUS_OFFSET, 32'h0000_0006, 32'h0000_0006);
        wait_ident(1'b0);
        rdchk(STATUS_OFFSET, 32'h0000_3CB6, exp);
        cardInfo <= ~cardInfo;
        repeat (10) @(posedge clk_sys);
        rdchk(STATUS_OFFSET, 32'h0000_3CB0, exp);
        $display("insertion test done");
    endtask : test_insert

    task automatic test_remove;
        present <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rdchk(STATUS_OFFSET, 32'h0000_0006, 32'h0000_0006);
        rdchk(EVENT_OFFSET, 32'h0000_0006, 32'h0000_0006);
        reg_write(EVENT_OFFSET, 32'h0000_000F);
        $display("removal test done");
    endtask : test_remove

    task automatic test_flags;
        @(posedge clk_sys);
        badSupplyReq <= 1'b1;
        removalLoss <= 1'b1;
        @(posedge clk_sys);
        badSupplyReq <= 1'b0;
        removalLoss <= 1'b0;
        rdchk(STATUS_OFFSET, 32'h0000_0300, 32'h0000_0300);
        reg_write(FORCE_OFFSET, 32'h0000_0000);
        rdchk(STATUS_OFFSET, 32'h0000_0300, 32'h0000_0000);
        reg_write(FORCE_OFFSET, 32'h0000_0800);
        rdchk(STATUS_OFFSET, 32'h0000_3C00, 32'h0000_0C00);
        check({31'h0, powerControlEnable}, 32'h0000_0000);
        // the card still in the socket answers the retest
        cardInfo <= '{accepts: 4'h1, cardBus: 1'b0, sixteenBit: 1'b1, unknown: 1'b0};
        reg_write(FORCE_OFFSET, 32'h0000_4000);
        wait_ident(1'b1);
        wait_ident(1'b0);
        rdchk(STATUS_OFFSET, 32'h0000_3C30, 32'h0000_0410);
        check({31'h0, powerControlEnable}, 32'h0000_0001);
        $display("flag and force test done");
    endtask : test_flags

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        addr = 8'h00;
        wrData = 32'h0000_0000;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        readyLevel = 1'b0;
        statusLevel = 1'b0;
        present = 1'b0;
        cardInfo = '0;
        badSupplyReq = 1'b0;
        removalLoss = 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        test_reset();
        test_power();
        test_pins(1'b0);
        test_insert(4'h2, 1'b1, 1'b0);
        test_pins(1'b1);
        test_remove();
        test_insert(4'h0, 1'b0, 1'b1);
        test_remove();
        test_insert(4'h1, 1'b0, 1'b0);
        test_flags();
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
